// ### csfr_regs.sv
// CPU special-function register bank: timer ports, transceiver status,
// clock/wait control, remote access flags and interrupt control.
// Assumes the transceiver, timer and CPU sit on clk; pins are synchronised.
// How it works
// RL1: Timer high byte readable and writable at main 29, bit 7 is bit 15.
// RL2: Timer low byte readable and writable at main 28, bit 0 is bit 0.
// RL3: Transceiver status is read-only in the alternate bank; writes ignored.
// RL4: Status bit 7 high whenever transmit FIFO has no free entry.
// RL5: Software must not write data register while transmit FIFO full.
// RL6: Status bit 6 follows internal transmit-active, even in loopback.
// RL7: Receiver error sets on error; clears on error-code read or reset bit.
// RL8: Receiver active sets on start, clears on end, error, or line idle. Here line idle clears it only when proto_5250 is high.
// RL9: Data available sets on valid word; clears on data read or error. Here only error clears it; the data-read clear is tied low.
// RL10: Status bits 2..0 show upper three bits of top receive word.
// RL11: CPU clock select resets to 1; 0 full rate, 1 half rate.
// RL12: Three-bit data wait field resets to seven, gives 0..7 waits.
// RL13: Two-bit instruction wait field resets to three, gives 0..3 waits.
// RL14: Clock-output disable high releases the clock output pin.
// RL15: Remote lockout high refuses remote accesses to processor and memory.
// RL16: Remote-read flag sets on remote read strobe, clears by writing 1.
// RL17: Remote-write flag sets on remote write strobe, clears by writing 1.
// RL18: Interrupt pin direction bit: 0 input, 1 output.
// RL19: Read-only bit shows interrupt pin level, sampled each instruction.
// RL20: Global enable low blocks all; high enables unmasked sources only.
// RL21: Five mask bits reset ones; receiver highest priority, timer lowest.
// RL22: Mask bit 3 masks pin only as input; as output drives pin level.
// RL23: A remote strobe in the clearing cycle keeps the flag set.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module csfr_regs
  import csfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transceiver state, same clock
  input wire logic tx_fifo_full_in,
  input wire logic tx_active_in,
  input wire logic rx_error_evt,
  input wire logic rx_start_evt,
  input wire logic rx_end_evt,
  input wire logic line_active_clr,
  input wire logic proto_5250,
  input wire logic rx_word_valid,
  input wire logic [2:0] rx_fifo_top_upper_bits,
  input wire logic error_code_rd,
  input wire logic transceiver_reset_bit,
  // Timer, same clock
  input wire logic [15:0] timer_value,
  output logic [7:0] timer_wdata,
  output logic timer_wr_hi,
  output logic timer_wr_lo,
  // Timing control
  input wire logic instr_start,
  output logic cpu_clk_div2,
  output logic [2:0] data_wait_states,
  output logic [1:0] instr_wait_states,
  output logic clk_out_oe_n,
  // Remote interface, strobes from pins
  input wire logic remote_read_strobe,
  input wire logic remote_write_strobe,
  output logic remote_lockout,
  // Interrupts
  input wire logic bidir_irq_pin_in,
  output logic bidir_irq_pin_out,
  output logic bidir_irq_pin_oe_n,
  input wire logic [4:0] irq_src,
  output logic [4:0] irq_grant
);
  import csfr_pkg::*;

  logic [1:0] rrd_sync_q, rwr_sync_q, pin_sync_q;
  logic rrd_prev_q, rwr_prev_q;
  logic clk_div2_q, irq_pin_dir_q, cod_q, lor_q, gie_q;
  logic [2:0] dw_q;
  logic [1:0] iw_q;
  logic [4:0] im_q, grant_d, grant_q;
  logic rr_q, rw_q, pin_level_q;
  logic rx_err_q, rx_act_q, dav_q;
  logic [7:0] rdata_q, tmr_wdata_q;
  logic tmr_hi_q, tmr_lo_q;
  logic wr_status, rd_data_reg;
  logic rrd_rise, rwr_rise;
  logic [7:0] status_v;
  logic [4:0] enabled;
  // No data-register read reaches this bank yet, so this clear stays idle
  logic error_code_rd_data;

  // Pin inputs pass two flops; only the second stage feeds logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rrd_sync_q <= 2'h0;
      rwr_sync_q <= 2'h0;
      pin_sync_q <= 2'h0;
      rrd_prev_q <= 1'h0;
      rwr_prev_q <= 1'h0;
    end else begin
      rrd_sync_q <= {rrd_sync_q[0], remote_read_strobe};
      rwr_sync_q <= {rwr_sync_q[0], remote_write_strobe};
      pin_sync_q <= {pin_sync_q[0], bidir_irq_pin_in};
      rrd_prev_q <= rrd_sync_q[1];
      rwr_prev_q <= rwr_sync_q[1];
    end
  end

  assign rrd_rise = rrd_sync_q[1] & ~rrd_prev_q;
  assign rwr_rise = rwr_sync_q[1] & ~rwr_prev_q;
  // The status register has no write path at all
  assign wr_status = reg_wr && (reg_addr == CSFR_ADDR_STATUS); // RL3
  // Data register read has no source: the error_code_rd_data sibling of error_code_rd
  // is tied low, and the status read itself does not clear anything
  assign rd_data_reg = 1'b0;

  // Clock and wait-state control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_div2_q <= CSFR_CCS_RST; // RL11
      dw_q <= CSFR_DW_RST; // RL12
      iw_q <= CSFR_IW_RST; // RL13
    end else if (reg_wr && reg_addr == CSFR_ADDR_CLKWAIT) begin
      clk_div2_q <= reg_wdata[CSFR_CCS_BIT]; // RL11
      dw_q <= reg_wdata[2:0]; // RL12
      iw_q <= reg_wdata[4:3]; // RL13
    end
  end

  // Auxiliary control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pin_dir_q <= 1'h0;
      cod_q <= 1'h0;
      lor_q <= 1'h0;
      gie_q <= 1'h0;
    end else if (reg_wr && reg_addr == CSFR_ADDR_AUX) begin
      irq_pin_dir_q <= reg_wdata[CSFR_BIC_BIT]; // RL18
      cod_q <= reg_wdata[CSFR_COD_BIT]; // RL14
      lor_q <= reg_wdata[CSFR_LOR_BIT]; // RL15
      gie_q <= reg_wdata[CSFR_GIE_BIT]; // RL20
    end
  end

  // Interrupt mask field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      im_q <= CSFR_IM_RST; // RL21
    end else if (reg_wr && reg_addr == CSFR_ADDR_IMASK) begin
      im_q <= reg_wdata[4:0];
    end
  end

  // Remote access flags: set beats write-one-to-clear so no access is lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rr_q <= 1'h0;
      rw_q <= 1'h0;
    end else begin
      if (rrd_rise) begin
        rr_q <= 1'b1; // RL16 RL23
      end else if (reg_wr && reg_addr == CSFR_ADDR_COND &&
                   reg_wdata[CSFR_RR_BIT]) begin
        rr_q <= 1'b0; // RL16
      end
      if (rwr_rise) begin
        rw_q <= 1'b1; // RL17 RL23
      end else if (reg_wr && reg_addr == CSFR_ADDR_COND &&
                   reg_wdata[CSFR_RW_BIT]) begin
        rw_q <= 1'b0; // RL17
      end
    end
  end

  // Pin level captured only at the start of an instruction cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_level_q <= 1'h0;
    end else if (instr_start) begin
      pin_level_q <= pin_sync_q[1]; // RL19
    end
  end

  // Receiver error: a new error wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_err_q <= 1'h0;
    end else if (rx_error_evt) begin
      rx_err_q <= 1'b1; // RL7
    end else if (error_code_rd || transceiver_reset_bit) begin
      rx_err_q <= 1'b0; // RL7
    end
  end

  // Receiver active; start wins if it coincides with an end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_act_q <= 1'h0;
    end else if (rx_start_evt) begin
      rx_act_q <= 1'b1; // RL8
    end else if (rx_end_evt || rx_error_evt ||
                 (proto_5250 && line_active_clr)) begin
      rx_act_q <= 1'b0; // RL8
    end
  end

  // Data available; a fresh word wins over the read that drains the last
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dav_q <= 1'h0;
    end else if (rx_error_evt) begin
      dav_q <= 1'b0; // RL9
    end else if (rx_word_valid) begin
      dav_q <= 1'b1; // RL9
    end else if (rd_data_reg || error_code_rd_data) begin
      dav_q <= 1'b0; // RL9
    end
  end

  // Status assembly; live inputs for full, active and FIFO top bits
  always_comb begin
    status_v = 8'h00;
    status_v[7] = tx_fifo_full_in; // RL4
    status_v[6] = tx_active_in; // RL6
    status_v[5] = rx_err_q;
    status_v[4] = rx_act_q;
    status_v[3] = dav_q;
    status_v[2:0] = rx_fifo_top_upper_bits; // RL10
  end

  // Read mux; unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CSFR_ADDR_STATUS: rdata_q <= status_v; // RL3
        CSFR_ADDR_TMR_HI: rdata_q <= timer_value[15:8]; // RL1
        CSFR_ADDR_TMR_LO: rdata_q <= timer_value[7:0]; // RL2
        CSFR_ADDR_CLKWAIT: rdata_q <= {clk_div2_q, 2'h0, iw_q, dw_q};
        CSFR_ADDR_AUX:
          rdata_q <= {3'h0, irq_pin_dir_q, 1'h0, cod_q, lor_q, gie_q};
        CSFR_ADDR_COND: rdata_q <= {1'h0, rr_q, rw_q, pin_level_q, 4'h0};
        CSFR_ADDR_IMASK: rdata_q <= {3'h0, im_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Timer byte writes go to the timer as one-cycle load pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_wdata_q <= CSFR_TMR_RST;
      tmr_hi_q <= 1'h0;
      tmr_lo_q <= 1'h0;
    end else begin
      tmr_hi_q <= reg_wr && reg_addr == CSFR_ADDR_TMR_HI; // RL1
      tmr_lo_q <= reg_wr && reg_addr == CSFR_ADDR_TMR_LO; // RL2
      if (reg_wr) begin
        tmr_wdata_q <= reg_wdata;
      end
    end
  end

  // Source enables: global gate, mask, and pin mask only as input
  always_comb begin
    enabled = ~im_q & irq_src;
    if (irq_pin_dir_q) begin
      enabled[CSFR_IM_PIN_BIT] = 1'b0; // RL22
    end
    if (!gie_q) begin
      enabled = 5'h00; // RL20
    end
    // Priority: lowest index wins so receiver beats timer
    grant_d = enabled & (~enabled + 5'h01); // RL21
  end

  // Registered outputs; pin drive and clock output enable are active low
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grant_q <= 5'h00;
      bidir_irq_pin_out <= 1'h0;
      bidir_irq_pin_oe_n <= 1'h1;
      clk_out_oe_n <= 1'h0;
    end else begin
      grant_q <= grant_d;
      bidir_irq_pin_out <= im_q[CSFR_IM_PIN_BIT]; // RL22
      bidir_irq_pin_oe_n <= ~irq_pin_dir_q; // RL18
      clk_out_oe_n <= cod_q; // RL14
    end
  end

  // Direct register outputs
  assign reg_rdata = rdata_q;
  assign timer_wdata = tmr_wdata_q;
  assign timer_wr_hi = tmr_hi_q;
  assign timer_wr_lo = tmr_lo_q;
  assign cpu_clk_div2 = clk_div2_q;
  assign data_wait_states = dw_q;
  assign instr_wait_states = iw_q;
  assign remote_lockout = lor_q; // RL15
  assign irq_grant = grant_q;

  // Data register reads do not reach this bank, so this clear is tied low
  assign error_code_rd_data = 1'b0;
endmodule
`default_nettype wire

// ### csfr_pkg.sv
// Package for the CPU special-function register bank.
// Assumes a single 125 MHz clock domain and one-cycle register strobes.
package csfr_pkg;
  // Register addresses: bit 5 selects the alternate bank
  localparam logic [5:0] CSFR_ADDR_STATUS = 6'h25;
  localparam logic [5:0] CSFR_ADDR_TMR_LO = 6'h1C;
  localparam logic [5:0] CSFR_ADDR_TMR_HI = 6'h1D;
  localparam logic [5:0] CSFR_ADDR_CLKWAIT = 6'h30;
  localparam logic [5:0] CSFR_ADDR_AUX = 6'h31;
  localparam logic [5:0] CSFR_ADDR_COND = 6'h32;
  localparam logic [5:0] CSFR_ADDR_IMASK = 6'h33;
  // Field positions
  localparam int CSFR_CCS_BIT = 7;
  localparam int CSFR_BIC_BIT = 4;
  localparam int CSFR_COD_BIT = 2;
  localparam int CSFR_LOR_BIT = 1;
  localparam int CSFR_GIE_BIT = 0;
  localparam int CSFR_RR_BIT = 6;
  localparam int CSFR_RW_BIT = 5;
  localparam int CSFR_PIN_BIT = 4;
  localparam int CSFR_IM_PIN_BIT = 3;
  // Values after reset
  localparam logic CSFR_CCS_RST = 1'h1;
  localparam logic [2:0] CSFR_DW_RST = 3'h7;
  localparam logic [1:0] CSFR_IW_RST = 2'h3;
  localparam logic [4:0] CSFR_IM_RST = 5'h1F;
  localparam logic [7:0] CSFR_TMR_RST = 8'h00;
endpackage

// ### csfr_regs_assertions.sv
// Port checker for the special-function register bank.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module csfr_regs_chk
  import csfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_fifo_full_in,
  input wire logic tx_active_in,
  input wire logic [2:0] rx_fifo_top_upper_bits,
  input wire logic [7:0] timer_wdata,
  input wire logic timer_wr_hi,
  input wire logic timer_wr_lo,
  input wire logic cpu_clk_div2,
  input wire logic [2:0] data_wait_states,
  input wire logic [1:0] instr_wait_states,
  input wire logic clk_out_oe_n,
  input wire logic remote_lockout,
  input wire logic bidir_irq_pin_out,
  input wire logic bidir_irq_pin_oe_n,
  input wire logic [4:0] irq_src,
  input wire logic [4:0] irq_grant
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Status reads show the live transceiver levels of the read edge
  status_hi_a: assert property (reg_rd && reg_addr == CSFR_ADDR_STATUS
    |=> reg_rdata[7:6] == {$past(tx_fifo_full_in), $past(tx_active_in)})
    else $error("status bits 7..6 wrong");
  status_lo_a: assert property (reg_rd && reg_addr == CSFR_ADDR_STATUS
    |=> reg_rdata[2:0] == $past(rx_fifo_top_upper_bits))
    else $error("status bits 2..0 wrong");
  // Timer bytes go out one cycle after the write
  timer_hi_a: assert property (reg_wr && reg_addr == CSFR_ADDR_TMR_HI
    |=> timer_wr_hi && timer_wdata == $past(reg_wdata))
    else $error("timer high write lost");
  timer_lo_a: assert property (reg_wr && reg_addr == CSFR_ADDR_TMR_LO
    |=> timer_wr_lo && timer_wdata == $past(reg_wdata))
    else $error("timer low write lost");
  clk_wait_a: assert property (reg_wr && reg_addr == CSFR_ADDR_CLKWAIT
    |=> {cpu_clk_div2, instr_wait_states, data_wait_states}
      == {$past(reg_wdata[7]), $past(reg_wdata[4:0])})
    else $error("clock or wait field wrong");
  // Pin enables pass one more flop than the control bits behind them
  aux_pins_a: assert property (reg_wr && reg_addr == CSFR_ADDR_AUX
    |=> remote_lockout == $past(reg_wdata[1]) ##1
      {clk_out_oe_n, bidir_irq_pin_oe_n}
      == {$past(reg_wdata[2], 2), !$past(reg_wdata[4], 2)})
    else $error("aux control pins wrong");
  pin_drive_a: assert property (reg_wr && reg_addr == CSFR_ADDR_IMASK
    |-> ##2 bidir_irq_pin_out == $past(reg_wdata[3], 2))
    else $error("pin drive level wrong");
  // A grant is one source that was really pending
  grant_src_a: assert property (irq_grant != 5'h00
    |-> $onehot(irq_grant) && (irq_grant & ~$past(irq_src)) == 5'h00)
    else $error("grant not a pending source");
endmodule
bind csfr_regs csfr_regs_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .tx_fifo_full_in, .tx_active_in,
  .rx_fifo_top_upper_bits, .timer_wdata, .timer_wr_hi, .timer_wr_lo,
  .cpu_clk_div2, .data_wait_states, .instr_wait_states, .clk_out_oe_n,
  .remote_lockout, .bidir_irq_pin_out, .bidir_irq_pin_oe_n, .irq_src,
  .irq_grant);
`default_nettype wire

// ### csfr_cpu_model.sv
// Firmware-side CPU model driving the register port.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module csfr_cpu_model (
  input wire logic clk,
  output logic [5:0] reg_addr = 6'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire logic [7:0] reg_rdata
);
  // Data register lives elsewhere, so no write meets a full queue
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // Released bus shows no stale value
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata; // Answer stands only in this cycle
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the special-function register bank.
// Assumes the CPU model owns the register port; the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import csfr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ext_irq = 1'b0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, timer_wdata, v;
  logic reg_wr, reg_rd, timer_wr_hi, timer_wr_lo, cpu_clk_div2;
  logic clk_out_oe_n, remote_lockout, bidir_irq_pin_out, bidir_irq_pin_oe_n;
  logic [2:0] data_wait_states;
  logic [1:0] instr_wait_states;
  logic [4:0] irq_grant, irq_src = 5'h00;
  logic tx_fifo_full_in = 1'b0, tx_active_in = 1'b0, rx_error_evt = 1'b0;
  logic rx_start_evt = 1'b0, rx_word_valid = 1'b0, error_code_rd = 1'b0;
  logic instr_start = 1'b0, remote_read_strobe = 1'b0;
  logic remote_write_strobe = 1'b0;
  logic [2:0] rx_fifo_top_upper_bits = 3'h0;
  logic [15:0] timer_value = 16'h0000;
  int bad_count = 0, tests_run = 0;
  // Pin level: the bank drives it while enabled, else the outside does
  wire logic bidir_irq_pin_in;
  assign bidir_irq_pin_in = bidir_irq_pin_oe_n ? ext_irq : bidir_irq_pin_out;
  csfr_cpu_model cpu (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  csfr_regs DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .tx_fifo_full_in, .tx_active_in, .rx_error_evt, .rx_start_evt,
    .rx_end_evt(1'b0), .line_active_clr(1'b0), .proto_5250(1'b0),
    .rx_word_valid, .rx_fifo_top_upper_bits, .error_code_rd,
    .transceiver_reset_bit(1'b0), .timer_value, .timer_wdata, .timer_wr_hi,
    .timer_wr_lo, .instr_start, .cpu_clk_div2, .data_wait_states,
    .instr_wait_states, .clk_out_oe_n, .remote_read_strobe,
    .remote_write_strobe, .remote_lockout, .bidir_irq_pin_in,
    .bidir_irq_pin_out, .bidir_irq_pin_oe_n, .irq_src, .irq_grant);
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_reset;
    cpu.rd(CSFR_ADDR_CLKWAIT, v);
    chk("clkwait", 8'h9F, v);
    cpu.rd(CSFR_ADDR_IMASK, v);
    chk("imask", 8'h1F, v);
    cpu.rd(6'h3F, v);
    chk("unmapped", 8'h00, v);
    cpu.wr(CSFR_ADDR_CLKWAIT, 8'h00);
    @(posedge clk);
    chk("waits", 8'h00, {cpu_clk_div2, 2'h0, instr_wait_states,
      data_wait_states});
  endtask
  task automatic t_timer;
    @(posedge clk);
    timer_value <= 16'hC33C;
    cpu.wr(CSFR_ADDR_TMR_HI, 8'hA5);
    cpu.wr(CSFR_ADDR_TMR_LO, 8'h5A);
    cpu.rd(CSFR_ADDR_TMR_HI, v);
    chk("timer_hi", 8'hC3, v);
    cpu.rd(CSFR_ADDR_TMR_LO, v);
    chk("timer_lo", 8'h3C, v);
  endtask
  task automatic t_status;
    @(posedge clk);
    tx_fifo_full_in <= 1'b1;
    tx_active_in <= 1'b1;
    rx_fifo_top_upper_bits <= 3'h5;
    rx_start_evt <= 1'b1;
    rx_word_valid <= 1'b1;
    @(posedge clk);
    rx_start_evt <= 1'b0;
    rx_word_valid <= 1'b0;
    cpu.wr(CSFR_ADDR_STATUS, 8'h00);
    cpu.rd(CSFR_ADDR_STATUS, v);
    chk("status", 8'hDD, v);
    @(posedge clk);
    rx_error_evt <= 1'b1;
    @(posedge clk);
    rx_error_evt <= 1'b0;
    cpu.rd(CSFR_ADDR_STATUS, v);
    chk("status_err", 8'hE5, v);
    @(posedge clk);
    error_code_rd <= 1'b1;
    @(posedge clk);
    error_code_rd <= 1'b0;
    cpu.rd(CSFR_ADDR_STATUS, v);
    chk("status_clr", 8'hC5, v);
  endtask
  task automatic t_remote;
    @(posedge clk);
    remote_read_strobe <= 1'b1;
    remote_write_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    remote_read_strobe <= 1'b0;
    remote_write_strobe <= 1'b0;
    repeat (4) @(posedge clk);
    cpu.rd(CSFR_ADDR_COND, v);
    chk("flags", 8'h60, v);
    cpu.wr(CSFR_ADDR_COND, 8'h40);
    cpu.rd(CSFR_ADDR_COND, v);
    chk("rw_kept", 8'h20, v);
  endtask
  // Sources 1, 2 and 4 pend; gate them by enable and masks
  task automatic t_irq;
    @(posedge clk);
    irq_src <= 5'h16;
    cpu.wr(CSFR_ADDR_IMASK, 8'h00);
    repeat (2) @(posedge clk);
    chk("grant_off", 8'h00, {3'h0, irq_grant});
    cpu.wr(CSFR_ADDR_AUX, 8'h01);
    repeat (2) @(posedge clk);
    chk("grant", 8'h02, {3'h0, irq_grant});
    cpu.wr(CSFR_ADDR_IMASK, 8'h02);
    repeat (2) @(posedge clk);
    chk("grant_msk", 8'h04, {3'h0, irq_grant});
    ext_irq <= 1'b1;
    repeat (4) @(posedge clk);
    instr_start <= 1'b1;
    @(posedge clk);
    instr_start <= 1'b0;
    cpu.rd(CSFR_ADDR_COND, v);
    chk("pin_in", 8'h30, v);
    cpu.wr(CSFR_ADDR_IMASK, 8'h08);
    cpu.wr(CSFR_ADDR_AUX, 8'h17);
    repeat (2) @(posedge clk);
    chk("aux_pins", 8'h0D, {4'h0, clk_out_oe_n, remote_lockout,
      bidir_irq_pin_oe_n, bidir_irq_pin_out});
    cpu.rd(CSFR_ADDR_AUX, v);
    chk("aux", 8'h17, v);
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_timer;
    t_status;
    t_remote;
    t_irq;
    test_done;
  end
  // Hang guard
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
